// ---- rtl/crb_top.sv ----
// Two CAN receive buffers with error counter, register port and interrupt
//
// How it works
// R1: full flag set on store, software clears
// R2: mode selects all valid, standard, extended or all
// R3: buffer 0 overflow goes to buffer 1 only enabled
// R4: jump offset bit reads double buffer enable
// R5: buffer 0 hit bit names filter 0 or 1
// R6: buffer 1 hit field holds filter code
// R7: control remote flag follows stored frame
// R8: standard identifier packs high byte, low bits
// R9: extended identifier top bits fill same bytes
// R10: extended registers hold identifier low sixteen
// R11: substitute remote bit zero when extended frame
// R12: length register keeps remote request bit
// R13: length code stored as received, codes 9+ invalid
// R14: eight data bytes per buffer, in order
// R15: error counter read-only, above 127 passive
// R16: error counter never causes bus-off
// R17: unimplemented bits read zero
// R18: store only into empty buffer, then full
// R19: full and mode kept separately per buffer
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module crb_top import crb_pkg::*; (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // Register port
    input wire crb_bus_t BUS,
    output logic [7:0] RDATA,
    // Frames from the protocol engine
    input wire logic FRAME_VALID,
    input wire crb_frame_t FRAME,
    input wire crb_err_t ERR_EVENT,
    // Status
    output logic ERROR_PASSIVE,
    output logic IRQ
);

    // ************************************************************
    // Acceptance check
    // ************************************************************
    function automatic logic mode_accepts(input logic [1:0] mode, input logic ext,
                                          input logic err);
        logic ok;
        ok = 1'b0;
        unique case (crb_mode_t'(mode))
            MODE_ALL: ok = 1'b1;
            MODE_EXT_ONLY: ok = ~err & ext;
            MODE_STD_ONLY: ok = ~err & ~ext;
            MODE_ALL_VALID: ok = ~err;
        endcase
        return ok;
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic full0;
    logic full1;
    logic [1:0] mode0;
    logic [1:0] mode1;
    logic dben;
    logic hit0;
    logic [2:0] hit1;
    logic [7:0] rec;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic rtr0;
    logic rtr1;
    logic [7:0] slot0_byte;
    logic [7:0] slot1_byte;

    // ************************************************************
    // Decode
    // ************************************************************
    wire logic [3:0] page = BUS.addr[7:4];
    wire logic [3:0] idx = BUS.addr[3:0];
    wire logic sel0 = page == BUF0_PAGE;
    wire logic sel1 = page == BUF1_PAGE;
    wire logic wr_ctrl0 = BUS.wr && sel0 && idx == IDX_CONTROL;
    wire logic wr_ctrl1 = BUS.wr && sel1 && idx == IDX_CONTROL;
    wire logic wr_status = BUS.wr && BUS.addr == ADDR_INT_STATUS;
    wire logic wr_mask = BUS.wr && BUS.addr == ADDR_INT_MASK;
    // Clearable bit: writing zero releases the buffer, writing one does nothing
    wire logic clr0 = wr_ctrl0 && !BUS.wdata[CTRL_FULL_BIT]; // R1
    wire logic clr1 = wr_ctrl1 && !BUS.wdata[CTRL_FULL_BIT]; // R1

    // ************************************************************
    // Routing of a received frame
    // ************************************************************
    wire logic to_buf0 = FRAME.filter < 3'd2;
    wire logic ok0 = mode_accepts(mode0, FRAME.ext, FRAME.err); // R2
    wire logic ok1 = mode_accepts(mode1, FRAME.ext, FRAME.err); // R2
    wire logic store0 = FRAME_VALID && to_buf0 && ok0 && !full0; // R18
    wire logic spill = FRAME_VALID && to_buf0 && ok0 && full0 && dben; // R3
    wire logic store1 = !full1 && ok1 && (spill || (FRAME_VALID && !to_buf0)); // R3 R18
    wire logic lost = FRAME_VALID && !store0 && !store1
                      && ((to_buf0 && ok0) || (!to_buf0 && ok1));

    // ************************************************************
    // Control registers
    // ************************************************************
    wire logic [7:0] ctrl0_image = {full0, mode0, 1'b0, rtr0, dben, dben, hit0}; // R4 R5 R17
    wire logic [7:0] ctrl1_image = {full1, mode1, 1'b0, rtr1, hit1}; // R6 R17

    always_ff @(posedge CLK) begin
        if (RESET) begin
            full0 <= 1'b0;
            full1 <= 1'b0;
        end else begin
            // A store in the clearing cycle wins
            full0 <= store0 | (full0 & ~clr0); // R1 R18 R19
            full1 <= store1 | (full1 & ~clr1); // R1 R18 R19
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            mode0 <= MODE_RESET;
            mode1 <= MODE_RESET;
            dben <= 1'b0;
        end else begin
            if (wr_ctrl0) begin
                mode0 <= BUS.wdata[CTRL_MODE_LSB +: 2]; // R19
                dben <= BUS.wdata[CTRL_DBEN_BIT]; // R3
            end
            if (wr_ctrl1) begin
                mode1 <= BUS.wdata[CTRL_MODE_LSB +: 2]; // R19
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            hit0 <= 1'b0;
            hit1 <= 3'b000;
        end else begin
            if (store0) begin
                hit0 <= FRAME.filter[0]; // R5
            end
            if (store1) begin
                hit1 <= FRAME.filter; // R6
            end
        end
    end

    // ************************************************************
    // Buffer storage
    // ************************************************************
    crb_rx_slot u_slot0 (
        .clk(CLK),
        .reset(RESET),
        .load(store0),
        .frame(FRAME),
        .wr_en(BUS.wr && sel0),
        .wr_idx(idx),
        .wr_data(BUS.wdata),
        .rd_idx(idx),
        .rd_byte(slot0_byte),
        .rtr_flag(rtr0)
    );

    crb_rx_slot u_slot1 (
        .clk(CLK),
        .reset(RESET),
        .load(store1),
        .frame(FRAME),
        .wr_en(BUS.wr && sel1),
        .wr_idx(idx),
        .wr_data(BUS.wdata),
        .rd_idx(idx),
        .rd_byte(slot1_byte),
        .rtr_flag(rtr1)
    );

    // ************************************************************
    // Receive error counter
    // ************************************************************
    logic [7:0] next_rec;

    always_comb begin
        next_rec = rec;
        if (ERR_EVENT.rx_error_severe) begin
            next_rec = (rec > REC_MAX - REC_STEP_SEVERE) ? REC_MAX : rec + REC_STEP_SEVERE;
        end else if (ERR_EVENT.rx_error) begin
            next_rec = (rec == REC_MAX) ? REC_MAX : rec + 8'h01;
        end else if (ERR_EVENT.rx_success) begin
            if (rec > REC_PASSIVE_LIMIT) begin
                next_rec = REC_RELOAD; // R15
            end else if (rec != BYTE_ZERO) begin
                next_rec = rec - 8'h01; // R15
            end
        end
    end

    // Saturates instead of wrapping, so it can only reach error passive
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rec <= BYTE_ZERO; // R15
            ERROR_PASSIVE <= 1'b0;
        end else begin
            rec <= next_rec; // R16
            ERROR_PASSIVE <= next_rec > REC_PASSIVE_LIMIT; // R15 R16
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    wire logic [3:0] int_events = {
        !ERROR_PASSIVE && next_rec > REC_PASSIVE_LIMIT, lost, store1, store0
    };

    always_ff @(posedge CLK) begin
        if (RESET) begin
            int_status <= INT_RESET;
            int_mask <= INT_RESET;
            IRQ <= 1'b0;
        end else begin
            int_status <= int_events | (int_status & ~(wr_status ? BUS.wdata[3:0] : 4'h0));
            if (wr_mask) begin
                int_mask <= BUS.wdata[3:0];
            end
            IRQ <= |(int_status & int_mask);
        end
    end

    // ************************************************************
    // Read port, data one cycle after the strobe
    // ************************************************************
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = BYTE_ZERO;
        if (sel0) begin
            next_rdata = (idx == IDX_CONTROL) ? ctrl0_image : slot0_byte;
        end else if (sel1) begin
            next_rdata = (idx == IDX_CONTROL) ? ctrl1_image : slot1_byte;
        end else if (BUS.addr == ADDR_ERROR_COUNT) begin
            next_rdata = rec; // R15
        end else if (BUS.addr == ADDR_INT_STATUS) begin
            next_rdata = {4'h0, int_status};
        end else if (BUS.addr == ADDR_INT_MASK) begin
            next_rdata = {4'h0, int_mask};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge CLK) begin
        if (RESET) begin
            RDATA <= BYTE_ZERO;
        end else begin
            RDATA <= BUS.rd ? next_rdata : BYTE_ZERO;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    AST_FULL_ON_STORE: assert property ( // R1
        FRAME_VALID && to_buf0 && ok0 && !full0 |=> full0 && hit0 == $past(FRAME.filter[0]))
        else $error("Buffer 0 not full after store");

    AST_FULL_HOLDS: assert property ( // R1
        full1 && !clr1 |=> full1)
        else $error("Buffer 1 full flag dropped without clear");

    AST_ERRORED_REJECTED: assert property ( // R2
        FRAME_VALID && FRAME.err && mode0 != MODE_ALL && mode1 != MODE_ALL
        |=> !$rose(full0) && !$rose(full1))
        else $error("Errored frame stored without receive-all mode");

    AST_NO_SPILL: assert property ( // R3
        FRAME_VALID && to_buf0 && !dben |=> !$rose(full1))
        else $error("Buffer 0 frame went to buffer 1 while disabled");

    AST_JUMP_COPY: assert property ( // R4
        BUS.rd && sel0 && idx == IDX_CONTROL |=> RDATA[1] == $past(dben) && RDATA[4] == 1'b0)
        else $error("Jump offset bit differs from enable");

    AST_HIT_FIELD: assert property ( // R6
        store1 |=> hit1 == $past(FRAME.filter) && full1)
        else $error("Buffer 1 hit field wrong");

    AST_SRR_READ: assert property ( // R11
        BUS.rd && sel0 && idx == IDX_IDENT_LOW
        |=> RDATA[SIDL_SRR_BIT] == ($past(rtr0) && !RDATA[SIDL_EXTENDED_FRAME_FLAG_BIT]))
        else $error("Substitute remote bit wrong");

    AST_PASSIVE: assert property ( // R15
        ERROR_PASSIVE == (rec > REC_PASSIVE_LIMIT))
        else $error("Error passive does not match counter");

    AST_REC_SEVERE: assert property ( // R15
        ERR_EVENT.rx_error_severe && rec < 8'h10 |=> rec == $past(rec) + REC_STEP_SEVERE)
        else $error("Counter did not step by eight");

    AST_IRQ_LEVEL: assert property (
        |(int_status & int_mask) |=> IRQ)
        else $error("Interrupt not raised");

    COV_STORE0: cover property (store0 ##1 full0);
    COV_SPILL: cover property (spill && store1);
    COV_PASSIVE: cover property ($rose(ERROR_PASSIVE));
    COV_IRQ: cover property ($rose(IRQ));

endmodule
`default_nettype wire

// ---- shared/crb_pkg.sv ----
// Shared constants and types for the CAN receive buffer block
package crb_pkg;

    // ************************************************************
    // Register map, byte addresses
    // ************************************************************
    localparam logic [3:0] BUF0_PAGE = 4'h0;
    localparam logic [3:0] BUF1_PAGE = 4'h1;
    localparam logic [3:0] IDX_CONTROL = 4'h0;
    localparam logic [3:0] IDX_IDENT_HIGH = 4'h1;
    localparam logic [3:0] IDX_IDENT_LOW = 4'h2;
    localparam logic [3:0] IDX_EXT_IDENT_HIGH = 4'h3;
    localparam logic [3:0] IDX_EXT_IDENT_LOW = 4'h4;
    localparam logic [3:0] IDX_LENGTH_CODE = 4'h5;
    localparam logic [3:0] IDX_DATA_FIRST = 4'h6;
    localparam logic [3:0] IDX_DATA_LAST = 4'hD;
    localparam logic [7:0] ADDR_ERROR_COUNT = 8'h20;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h21;
    localparam logic [7:0] ADDR_INT_MASK = 8'h22;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_FULL_BIT = 7;
    localparam int CTRL_MODE_LSB = 5;
    localparam int CTRL_DBEN_BIT = 2;
    localparam int SIDL_SRR_BIT = 4;
    localparam int SIDL_EXTENDED_FRAME_FLAG_BIT = 3;
    localparam int DLC_RTR_BIT = 6;
    localparam int INT_RX0 = 0;
    localparam int INT_RX1 = 1;
    localparam int INT_OVERFLOW = 2;
    localparam int INT_PASSIVE = 3;

    // ************************************************************
    // Values after reset and counter limits
    // ************************************************************
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] MODE_RESET = 2'b00;
    localparam logic [3:0] INT_RESET = 4'h0;
    localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
    localparam logic [7:0] REC_RELOAD = 8'h78;
    localparam logic [7:0] REC_MAX = 8'hFF;
    localparam logic [7:0] REC_STEP_SEVERE = 8'h08;

    // ************************************************************
    // Enumerations and carriers
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_ALL_VALID = 2'b00,
        MODE_STD_ONLY = 2'b01,
        MODE_EXT_ONLY = 2'b10,
        MODE_ALL = 2'b11
    } crb_mode_t;

    typedef struct packed {
        logic [28:0] ident;
        logic ext;
        logic rtr;
        logic err;
        logic [3:0] dlc;
        logic [2:0] filter;
        logic [63:0] data;
    } crb_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } crb_bus_t;

    typedef struct packed {
        logic rx_error;
        logic rx_error_severe;
        logic rx_success;
    } crb_err_t;

endpackage

// ---- rtl/crb_rx_slot.sv ----
// Storage of one receive buffer: identifier, length code and data bytes
`timescale 1ns/1ps
`default_nettype none
module crb_rx_slot import crb_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Frame load
    input wire logic load,
    input wire crb_frame_t frame,
    // Software access
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] rd_idx,
    output logic [7:0] rd_byte,
    output logic rtr_flag
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] ident_high;
    logic [2:0] ident_low3;
    logic ext_flag;
    logic [1:0] ext_mid;
    logic [7:0] ext_high;
    logic [7:0] ext_low;
    logic len_rtr;
    logic [3:0] len_code;
    logic [7:0] data_mem [0:7];
    logic [2:0] wr_slot;
    logic [2:0] rd_slot;
    logic [7:0] sidl_image;

    assign wr_slot = 3'(wr_idx - IDX_DATA_FIRST);
    assign rd_slot = 3'(rd_idx - IDX_DATA_FIRST);
    // Substitute remote bit is derived, never stored
    assign sidl_image = {ident_low3, ~ext_flag & rtr_flag, ext_flag, 1'b0, ext_mid}; // R11 R17

    always_ff @(posedge clk) begin
        if (reset) begin
            rtr_flag <= 1'b0;
        end else if (load) begin
            rtr_flag <= frame.rtr; // R7
        end
    end

    always_ff @(posedge clk) begin
        if (load) begin
            if (frame.ext) begin
                ident_high <= frame.ident[28:21]; // R9
                ident_low3 <= frame.ident[20:18]; // R9
                ext_mid <= frame.ident[17:16]; // R9
                ext_high <= frame.ident[15:8]; // R10
                ext_low <= frame.ident[7:0]; // R10
            end else begin
                ident_high <= frame.ident[10:3]; // R8
                ident_low3 <= frame.ident[2:0]; // R8
                ext_mid <= 2'b00;
                ext_high <= BYTE_ZERO;
                ext_low <= BYTE_ZERO;
            end
            ext_flag <= frame.ext; // R8
            len_rtr <= frame.rtr; // R12
            len_code <= frame.dlc; // R13
            for (int m = 0; m < 8; m++) begin
                data_mem[m] <= frame.data[8*m +: 8]; // R14
            end
        end else if (wr_en) begin
            if (wr_idx == IDX_IDENT_HIGH) begin
                ident_high <= wr_data;
            end
            if (wr_idx == IDX_IDENT_LOW) begin
                ident_low3 <= wr_data[7:5];
                ext_flag <= wr_data[SIDL_EXTENDED_FRAME_FLAG_BIT];
                ext_mid <= wr_data[1:0];
            end
            if (wr_idx == IDX_EXT_IDENT_HIGH) begin
                ext_high <= wr_data;
            end
            if (wr_idx == IDX_EXT_IDENT_LOW) begin
                ext_low <= wr_data;
            end
            if (wr_idx == IDX_LENGTH_CODE) begin
                len_rtr <= wr_data[DLC_RTR_BIT];
                len_code <= wr_data[3:0];
            end
            if (wr_idx >= IDX_DATA_FIRST && wr_idx <= IDX_DATA_LAST) begin
                data_mem[wr_slot] <= wr_data;
            end
        end
    end

    // ************************************************************
    // Read selection
    // ************************************************************
    always_comb begin
        rd_byte = BYTE_ZERO;
        if (rd_idx == IDX_IDENT_HIGH) begin
            rd_byte = ident_high;
        end else if (rd_idx == IDX_IDENT_LOW) begin
            rd_byte = sidl_image;
        end else if (rd_idx == IDX_EXT_IDENT_HIGH) begin
            rd_byte = ext_high;
        end else if (rd_idx == IDX_EXT_IDENT_LOW) begin
            rd_byte = ext_low;
        end else if (rd_idx == IDX_LENGTH_CODE) begin
            rd_byte = {1'b0, len_rtr, 2'b00, len_code}; // R17
        end else if (rd_idx >= IDX_DATA_FIRST && rd_idx <= IDX_DATA_LAST) begin
            rd_byte = data_mem[rd_slot]; // R14
        end
    end

endmodule
`default_nettype wire

// ---- bench/crb_frame_src.sv ----
// Model of the protocol engine that hands finished frames to the buffers
`timescale 1ns/1ps
`default_nettype none
module crb_frame_src import crb_pkg::*; (
    // Clock
    input wire logic clk,
    // Frame link
    output var logic frame_valid,
    output var crb_frame_t frame,
    output var crb_err_t err_event
);
    initial begin
        frame_valid = 1'b0;
        frame = '0;
        err_event = '0;
    end

    // ************************************************************
    // Frame hand-over
    // ************************************************************
    // Fields scrambled after the valid cycle so stale values never pass for a frame
    task automatic send(input crb_frame_t f);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame <= f;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame <= ~f;
    endtask

    // One counter event a call, one cycle long
    task automatic event_pulse(input crb_err_t e);
        @(posedge clk);
        err_event <= e;
        @(posedge clk);
        err_event <= '0;
    endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the two CAN receive buffers
`timescale 1ns/1ps
`default_nettype none
module testbench import crb_pkg::*;;
    logic CLK;
    logic RESET;
    crb_bus_t BUS;
    logic [7:0] RDATA;
    logic FRAME_VALID;
    crb_frame_t FRAME;
    crb_err_t ERR_EVENT;
    logic ERROR_PASSIVE;
    logic IRQ;
    logic [7:0] exp_q[$];
    logic rd_d;
    int error_cnt;
    int n_tests;
    crb_frame_t f;
    logic [7:0] ra[6] = '{8'h00, 8'h10, ADDR_ERROR_COUNT, ADDR_INT_STATUS, ADDR_INT_MASK, 8'h30};

    crb_top uut (.CLK(CLK), .RESET(RESET), .BUS(BUS), .RDATA(RDATA),
        .FRAME_VALID(FRAME_VALID), .FRAME(FRAME), .ERR_EVENT(ERR_EVENT),
        .ERROR_PASSIVE(ERROR_PASSIVE), .IRQ(IRQ));
    crb_frame_src src (.clk(CLK), .frame_valid(FRAME_VALID), .frame(FRAME),
        .err_event(ERR_EVENT));

    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // ************************************************************
    // Compare, bus cycles and closing
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (exp_q.size() != 0) error_cnt++;
        $display("Comparisons %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        BUS <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge CLK);
        BUS.wr <= 1'b0;
    endtask

    // Expected value queued; the monitor takes it in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        @(posedge CLK);
        BUS <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge CLK);
        BUS.rd <= 1'b0;
    endtask

    always @(posedge CLK) begin
        if (rd_d) chk(RDATA, exp_q.pop_front());
        rd_d <= BUS.rd;
    end

    function automatic crb_frame_t mk(input logic [28:0] id, input logic ext, input logic rtr,
        input logic err, input logic [3:0] dlc, input logic [2:0] fl, input logic [63:0] d);
        mk = '{ident: id, ext: ext, rtr: rtr, err: err, dlc: dlc, filter: fl, data: d};
    endfunction

    task automatic rd_buf(input logic [3:0] pg, input crb_frame_t g);
        rd({pg, IDX_IDENT_HIGH}, g.ext ? g.ident[28:21] : g.ident[10:3]);
        rd({pg, IDX_IDENT_LOW}, g.ext ? {g.ident[20:18], 3'b010, g.ident[17:16]}
            : {g.ident[2:0], g.rtr, 4'h0});
        if (g.ext) begin
            rd({pg, IDX_EXT_IDENT_HIGH}, g.ident[15:8]);
            rd({pg, IDX_EXT_IDENT_LOW}, g.ident[7:0]);
        end
        rd({pg, IDX_LENGTH_CODE}, {1'b0, g.rtr, 2'b00, g.dlc});
        for (int m = 0; m < 8; m++) rd({pg, IDX_DATA_FIRST + 4'(m)}, g.data[8*m +: 8]);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        RESET = 1'b1;
        BUS = '0;
        rd_d = 1'b0;
        error_cnt = 0;
        n_tests = 0;
        void'($urandom(90));
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        // Reset values, last one unmapped
        foreach (ra[i]) rd(ra[i], 8'h00);
        // Standard remote frame through filter 1
        f = mk(29'($urandom % 2048), 1'b0, 1'b1, 1'b0, 4'h8, 3'd1, {$urandom, $urandom});
        src.send(f);
        rd(8'h00, 8'h89);
        rd_buf(BUF0_PAGE, f);
        // Interrupt raised by unmasked store, then cleared
        rd(ADDR_INT_STATUS, 8'h01);
        wr(ADDR_INT_MASK, 8'h01);
        repeat (2) @(posedge CLK);
        #1 chk({7'h00, IRQ}, 8'h01);
        wr(ADDR_INT_STATUS, 8'h01);
        repeat (2) @(posedge CLK);
        #1 chk({7'h00, IRQ}, 8'h00);
        // Extended frame, invalid length code, filter 5
        f = mk(29'($urandom), 1'b1, 1'b0, 1'b0, 4'hF, 3'd5, {$urandom, $urandom});
        src.send(f);
        rd(8'h10, 8'h85);
        rd_buf(BUF1_PAGE, f);
        rd(8'h00, 8'h89);
        #1 chk({7'h00, IRQ}, 8'h00);
        // Overflow of buffer 0: lost while disabled, redirected once enabled
        wr(8'h10, 8'h00);
        src.send(mk(29'h0, 1'b0, 1'b0, 1'b0, 4'h1, 3'd0, 64'h0));
        rd(8'h10, 8'h05);
        rd(8'h00, 8'h89);
        rd(ADDR_INT_STATUS, 8'h06);
        wr(8'h00, 8'h84);
        rd(8'h00, 8'h8F);
        src.send(mk(29'h0, 1'b0, 1'b0, 1'b0, 4'h1, 3'd1, 64'h0));
        rd(8'h10, 8'h81);
        // Every mode against valid standard, valid extended and errored frames
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 3; k++) begin
                wr(8'h00, {1'b0, 2'(m), 5'h00});
                src.send(mk(29'h0, k == 1, 1'b0, k == 2, 4'h0, 3'd0, 64'h0));
                rd(8'h00, {(m == 3) || (k != 2 && (m == 0 || m == k + 1)), 2'(m), 5'h00});
            end
        end
        // Error counter: passive above 127, reload, saturation
        wr(ADDR_INT_STATUS, 8'hFF);
        repeat (16) src.event_pulse(3'b010);
        rd(ADDR_ERROR_COUNT, 8'h80);
        #1 chk({7'h00, ERROR_PASSIVE}, 8'h01);
        src.event_pulse(3'b001);
        rd(ADDR_ERROR_COUNT, 8'h78);
        #1 chk({7'h00, ERROR_PASSIVE}, 8'h00);
        src.event_pulse(3'b100);
        wr(ADDR_ERROR_COUNT, 8'h00);
        rd(ADDR_ERROR_COUNT, 8'h79);
        repeat (32) src.event_pulse(3'b010);
        rd(ADDR_ERROR_COUNT, 8'hFF);
        rd(ADDR_INT_STATUS, 8'h08);
        repeat (3) @(posedge CLK);
        complete_run();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
